/* logic/rcc_defines.svh */
// constants for the reject cause element codec: layout, lengths and cause codes
`ifndef RCC_DEFINES_SVH
`define RCC_DEFINES_SVH

// element layout: identifier, length of content, cause octet, diagnostic
`define RCC_HDR_OCTETS 4'h3
`define RCC_LEN_MIN 4'h3
`define RCC_LEN_MAX 4'he
`define RCC_LEN_ONE_DIAG_A 4'h6
`define RCC_LEN_ONE_DIAG_B 4'h7
`define RCC_CAUSE_EXT_BIT 1'b1

// diagnostic lengths in octets
`define RCC_DIAG_NONE 4'h0
`define RCC_DIAG_ISDN_TS 4'h3
`define RCC_DIAG_SINGLE 4'h4
`define RCC_DIAG_MAP 4'hb
`define RCC_DIAG_MAX_OCTETS 11

// cause type codes, seven bits
`define RCC_C_UNSPEC 7'h00
`define RCC_C_AN_FAULT 7'h01
`define RCC_C_AN_BLOCKED 7'h02
`define RCC_C_PSTN_BUSY 7'h03
`define RCC_C_V5TS_BUSY 7'h04
`define RCC_C_UPTS_BUSY 7'h05
`define RCC_C_PORT_BLOCKED 7'h06
`define RCC_C_DEALLOC_DATA 7'h07
`define RCC_C_DEALLOC_V5TS 7'h08
`define RCC_C_DEALLOC_PORT 7'h09
`define RCC_C_DEALLOC_UPTS 7'h0a
`define RCC_C_PORT_UNPROV 7'h0b
`define RCC_C_BAD_V5TS 7'h0c
`define RCC_C_BAD_LINK 7'h0d
`define RCC_C_BAD_UPTS 7'h0e
`define RCC_C_CCHAN 7'h0f
`define RCC_C_LINK_BLOCKED 7'h10

// element identifier octet of the reject cause element
`define RCC_IE_ID 8'h44

`endif

/* logic/rcc_pkg.sv */
// types and cause classification for the reject cause element codec
`include "rcc_defines.svh"

package rcc_pkg;

  // which diagnostic a cause carries
  typedef enum logic [2:0] {
    RCC_DG_NONE = 3'h0,
    RCC_DG_PORT = 3'h1,
    RCC_DG_V5 = 3'h2,
    RCC_DG_ISDN = 3'h3,
    RCC_DG_RESV = 3'h4
  } rcc_diag_e;

  typedef enum logic [4:0] {
    RCC_ST_IDLE = 5'h01,
    RCC_ST_ID = 5'h02,
    RCC_ST_LEN = 5'h04,
    RCC_ST_CAUSE = 5'h08,
    RCC_ST_DIAG = 5'h10
  } rcc_state_e;

  // map a cause code onto its diagnostic class; undefined codes are reserved
  function automatic rcc_diag_e cause_class(input logic [6:0] c);
    rcc_diag_e r;
    r = RCC_DG_RESV;
    case (c)
      `RCC_C_UNSPEC, `RCC_C_AN_FAULT, `RCC_C_AN_BLOCKED,
      `RCC_C_DEALLOC_DATA: r = RCC_DG_NONE;
      `RCC_C_PSTN_BUSY, `RCC_C_PORT_BLOCKED, `RCC_C_DEALLOC_PORT,
      `RCC_C_PORT_UNPROV: r = RCC_DG_PORT;
      `RCC_C_V5TS_BUSY, `RCC_C_DEALLOC_V5TS, `RCC_C_BAD_V5TS, `RCC_C_BAD_LINK,
      `RCC_C_CCHAN, `RCC_C_LINK_BLOCKED: r = RCC_DG_V5;
      `RCC_C_UPTS_BUSY, `RCC_C_DEALLOC_UPTS, `RCC_C_BAD_UPTS: r = RCC_DG_ISDN;
      default: r = RCC_DG_RESV;
    endcase
    return r;
  endfunction : cause_class

endpackage : rcc_pkg

/* logic/rcc_chk_if.sv */
// carrier between the framer and its length checker
interface rcc_chk_if;
  logic [6:0] cause;
  logic [3:0] diag_len;
  logic len_ok;
  logic reserved;

  modport framer (output cause, output diag_len, input len_ok, input reserved);
  modport checker_end (input cause, input diag_len, output len_ok, output reserved);
endinterface : rcc_chk_if

/* logic/rcc_len_check.sv */
// combinational check of cause code against diagnostic and element length
module rcc_len_check (
  rcc_chk_if.checker_end chk
);

  logic [3:0] total;
  rcc_pkg::rcc_diag_e cls;
  logic diag_ok;
  logic total_ok;

  // classify and test the pairing of cause and diagnostic length
  always_comb begin
    cls = rcc_pkg::cause_class(chk.cause);
    total = 4'(chk.diag_len + `RCC_HDR_OCTETS);
    diag_ok = 1'b0;
    unique case (cls)
      rcc_pkg::RCC_DG_NONE: diag_ok = (chk.diag_len == `RCC_DIAG_NONE);
      rcc_pkg::RCC_DG_PORT: diag_ok = (chk.diag_len == `RCC_DIAG_SINGLE);
      rcc_pkg::RCC_DG_V5: diag_ok = (chk.diag_len == `RCC_DIAG_SINGLE) ||
                                    (chk.diag_len == `RCC_DIAG_MAP);
      rcc_pkg::RCC_DG_ISDN: diag_ok = (chk.diag_len == `RCC_DIAG_ISDN_TS) ||
                                      (chk.diag_len == `RCC_DIAG_MAP);
      rcc_pkg::RCC_DG_RESV: diag_ok = 1'b0;
    endcase
    // overflow of the sum is caught by the explicit diagnostic limit
    total_ok = (chk.diag_len <= `RCC_DIAG_MAP) && (total >= `RCC_LEN_MIN) &&
               (total <= `RCC_LEN_MAX);
    if (chk.diag_len != `RCC_DIAG_NONE) begin
      total_ok = total_ok && ((total == `RCC_LEN_ONE_DIAG_A) ||
                 (total == `RCC_LEN_ONE_DIAG_B) || (total == `RCC_LEN_MAX));
    end
  end

  assign chk.len_ok = diag_ok && total_ok;
  assign chk.reserved = (cls == rcc_pkg::RCC_DG_RESV);

endmodule : rcc_len_check

/* logic/rcc_codec.sv */
// reject cause element framer on the access network side
//
// How it works
// - emit reject element when allocation fails
// - diagnostic is verbatim copy of offending element
// - element length three to fourteen octets
// - no-diagnostic causes give three-octet element
// - diagnostic causes give six, seven, fourteen
// - port busy 0000011, slots busy 0000100
// - port blocked 0000110, data dealloc 0000111
// - slot data 0001000, unprovisioned 0001011
// - link 0001101, port slot 0001110, link blocked 0010000
// - network fault and blocked carry no diagnostic
// - port causes carry four-octet port element
// - slot causes carry four or eleven octets
// - ISDN slot causes carry three or eleven
`include "rcc_defines.svh"

module rcc_codec #(
  parameter logic [7:0] IE_ID = `RCC_IE_ID
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic REQ_VALID_IN,
  output logic REQ_READY_OUT,
  input wire logic [6:0] REQ_CAUSE_IN,
  input wire logic [3:0] REQ_DIAG_LEN_IN,
  input wire logic [8*`RCC_DIAG_MAX_OCTETS-1:0] REQ_DIAG_IN,
  output logic REQ_ERR_OUT,
  output logic TX_VALID_OUT,
  input wire logic TX_READY_IN,
  output logic [7:0] TX_DATA_OUT,
  output logic TX_LAST_OUT
);

  localparam int NDIAG = `RCC_DIAG_MAX_OCTETS;

  // request store, loaded once per well-formed request
  logic [6:0] cause_q, cause_d;
  logic [3:0] len_q, len_d;
  logic [7:0] diag_q [0:NDIAG-1];
  logic [7:0] diag_d [0:NDIAG-1];

  // framing state and the registered octet on offer
  rcc_pkg::rcc_state_e state_q, state_d;
  logic [3:0] idx_q, idx_d;
  logic [7:0] data_q, data_d;
  logic valid_q, valid_d;
  logic last_q, last_d;
  logic err_q, err_d;

  // request handshake, store load and octet handshake
  logic accept;
  logic load;
  logic step;

  // carrier to the length checker
  rcc_chk_if chk ();

  // length octet counts the cause octet and the diagnostic, not itself
  function automatic logic [7:0] len_octet(input logic [3:0] diag_len);
    return {4'h0, 4'(diag_len + `RCC_HDR_OCTETS - 4'h2)};
  endfunction : len_octet

  // true when diagnostic octet pos is the final one of the element
  function automatic logic diag_final(input logic [3:0] pos, input logic [3:0] diag_len);
    return (4'(pos + 4'h1) == diag_len);
  endfunction : diag_final

  // request side is checked before anything is framed
  assign chk.cause = REQ_CAUSE_IN;
  assign chk.diag_len = REQ_DIAG_LEN_IN;

  rcc_len_check u_check (
    .chk(chk)
  );

  // one element in flight at a time, so the request waits while framing
  assign REQ_READY_OUT = (state_q == rcc_pkg::RCC_ST_IDLE);
  assign accept = REQ_VALID_IN && REQ_READY_OUT;
  assign load = accept && chk.len_ok;
  assign step = valid_q && TX_READY_IN;

  // request store: taken fields are kept until the element has gone out
  always_comb begin
    cause_d = cause_q;
    len_d = len_q;
    diag_d = diag_q;
    if (load) begin
      cause_d = REQ_CAUSE_IN;
      len_d = REQ_DIAG_LEN_IN;
      for (int i = 0; i < NDIAG; i++) begin
        diag_d[i] = REQ_DIAG_IN[8*i +: 8];
      end
    end
  end

  // cleared at reset so an element never carries octets of an earlier run
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cause_q <= `RCC_C_UNSPEC;
      len_q <= 4'h0;
      diag_q <= '{default: 8'h00};
    end else begin
      cause_q <= cause_d;
      len_q <= len_d;
      diag_q <= diag_d;
    end
  end

  // framing sequence: identifier, length, cause, diagnostic octets
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    data_d = data_q;
    valid_d = valid_q;
    last_d = last_q;
    err_d = 1'b0;
    unique case (state_q)
      // waiting for a request; a malformed pairing is never put on the line
      rcc_pkg::RCC_ST_IDLE: begin
        if (load) begin
          data_d = IE_ID;
          idx_d = 4'h0;
          valid_d = 1'b1;
          last_d = 1'b0;
          state_d = rcc_pkg::RCC_ST_ID;
        end else if (accept) begin
          err_d = 1'b1;
        end
      end

      // identifier on offer; the length octet follows
      rcc_pkg::RCC_ST_ID: begin
        if (step) begin
          data_d = len_octet(len_q);
          state_d = rcc_pkg::RCC_ST_LEN;
        end
      end

      // length on offer; the cause octet ends the element without diagnostic
      rcc_pkg::RCC_ST_LEN: begin
        if (step) begin
          data_d = {`RCC_CAUSE_EXT_BIT, cause_q};
          last_d = (len_q == `RCC_DIAG_NONE);
          state_d = rcc_pkg::RCC_ST_CAUSE;
        end
      end

      // cause on offer; either finish or start the diagnostic copy
      rcc_pkg::RCC_ST_CAUSE: begin
        if (step) begin
          if (last_q) begin
            valid_d = 1'b0;
            last_d = 1'b0;
            idx_d = 4'h0;
            state_d = rcc_pkg::RCC_ST_IDLE;
          end else begin
            data_d = diag_q[0];
            idx_d = 4'h1;
            last_d = diag_final(4'h0, len_q);
            state_d = rcc_pkg::RCC_ST_DIAG;
          end
        end
      end

      // a diagnostic octet on offer; idx_q picks the next one
      rcc_pkg::RCC_ST_DIAG: begin
        if (step) begin
          if (last_q) begin
            valid_d = 1'b0;
            last_d = 1'b0;
            idx_d = 4'h0;
            state_d = rcc_pkg::RCC_ST_IDLE;
          end else begin
            data_d = diag_q[idx_q];
            idx_d = 4'(idx_q + 4'h1);
            last_d = diag_final(idx_q, len_q);
            state_d = rcc_pkg::RCC_ST_DIAG;
          end
        end
      end

      // an upset state register falls back to idle with nothing offered
      default: begin
        state_d = rcc_pkg::RCC_ST_IDLE;
        valid_d = 1'b0;
        last_d = 1'b0;
      end
    endcase
  end

  // framing registers
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= rcc_pkg::RCC_ST_IDLE;
      idx_q <= 4'h0;
      data_q <= 8'h00;
      valid_q <= 1'b0;
      last_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      data_q <= data_d;
      valid_q <= valid_d;
      last_q <= last_d;
      err_q <= err_d;
    end
  end

  // outputs come straight from flops
  assign TX_VALID_OUT = valid_q;
  assign TX_DATA_OUT = data_q;
  assign TX_LAST_OUT = last_q;
  assign REQ_ERR_OUT = err_q;

endmodule : rcc_codec

/* verif/rcc_codec_assertions.sv */
// port assertions for the reject cause element framer
`include "rcc_defines.svh"
module rcc_codec_assertions #(
  parameter logic [7:0] IE_ID = `RCC_IE_ID
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic REQ_VALID_IN,
  input wire logic REQ_READY_OUT,
  input wire logic REQ_ERR_OUT,
  input wire logic TX_VALID_OUT,
  input wire logic TX_READY_IN,
  input wire logic [7:0] TX_DATA_OUT,
  input wire logic TX_LAST_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic [3:0] idx_q, idx_d;
  logic hs;
  // octet index inside the element; the final handshake clears it for the next one
  assign hs = TX_VALID_OUT && TX_READY_IN;
  always_comb begin
    idx_d = idx_q;
    if (hs) idx_d = TX_LAST_OUT ? 4'h0 : idx_q + 4'h1;
  end
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) idx_q <= 4'h0;
    else idx_q <= idx_d;
  end
  a_take_answers: assert property (
    REQ_VALID_IN && REQ_READY_OUT |=> TX_VALID_OUT != REQ_ERR_OUT)
    else $error("taken request got no single answer");
  a_first_id: assert property (
    $rose(TX_VALID_OUT) |-> TX_DATA_OUT == IE_ID && idx_q == 4'h0)
    else $error("element does not open with its identifier");
  a_len_octet: assert property (
    TX_VALID_OUT && idx_q == 4'h1 |-> TX_DATA_OUT inside {8'h01, 8'h04, 8'h05, 8'h0c})
    else $error("length octet out of range");
  a_cause_ext: assert property (
    TX_VALID_OUT && idx_q == 4'h2 |-> TX_DATA_OUT[7])
    else $error("cause octet top bit clear");
  a_last_pos: assert property (
    TX_VALID_OUT && TX_LAST_OUT |-> idx_q inside {4'h2, 4'h5, 4'h6, 4'hd})
    else $error("element ends at a bad octet count");
  a_stall_holds: assert property (
    TX_VALID_OUT && !TX_READY_IN |=>
      TX_VALID_OUT && $stable(TX_DATA_OUT) && $stable(TX_LAST_OUT))
    else $error("offered octet changed while stalled");
  a_busy_refuse: assert property (
    TX_VALID_OUT |-> !REQ_READY_OUT && !REQ_ERR_OUT)
    else $error("ready or error while sending");
  a_end_release: assert property (
    hs && TX_LAST_OUT |=> !TX_VALID_OUT && REQ_READY_OUT)
    else $error("not idle after final octet");
  a_nodiag_end: assert property (
    TX_VALID_OUT && idx_q == 4'h2 && TX_DATA_OUT[6:0] inside {7'h00, 7'h01, 7'h02, 7'h07}
      |-> TX_LAST_OUT)
    else $error("cause without diagnostic does not end the element");
  c_long: cover property (hs && TX_LAST_OUT && idx_q == 4'hd);
  c_short: cover property (hs && TX_LAST_OUT && idx_q == 4'h2);
  c_refused: cover property (REQ_ERR_OUT);
  c_stall: cover property (TX_VALID_OUT && !TX_READY_IN);
endmodule : rcc_codec_assertions

bind rcc_codec rcc_codec_assertions #(.IE_ID(IE_ID)) u_rcc_chk (.SYS_CLK_IN(SYS_CLK_IN),
  .RST_N_IN(RST_N_IN), .REQ_VALID_IN(REQ_VALID_IN), .REQ_READY_OUT(REQ_READY_OUT),
  .REQ_ERR_OUT(REQ_ERR_OUT), .TX_VALID_OUT(TX_VALID_OUT), .TX_READY_IN(TX_READY_IN),
  .TX_DATA_OUT(TX_DATA_OUT), .TX_LAST_OUT(TX_LAST_OUT));

/* verif/rcc_exchange_model.sv */
// exchange side sink: takes octets with random stalls and checks element length
module rcc_exchange_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  input wire logic last_in,
  output logic ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  integer seed = 61650;
  logic [7:0] oct [0:15];
  int n = 0;
  int elems = 0;
  int len_errs = 0;
  // stalls change off the sampling edge, like any other driver
  always @(negedge clk_in) ready_out <= rst_n_in && (!slow_in || $random(seed) & 1);
  // contents are stored, not judged; only the octet count and the length octet are checked
  always @(posedge clk_in) begin
    if (!rst_n_in) n = 0;
    else if (valid_in && ready_out) begin
      oct[n] = data_in;
      n = n + 1;
      if (last_in) begin
        if (!(n inside {3, 6, 7, 14}) || oct[1] != 8'(n - 2)) len_errs++;
        elems++;
        n = 0;
      end
    end
  end
endmodule : rcc_exchange_model

/* verif/rcc_codec_test.sv */
// self-checking bench for the reject cause element framer
`include "rcc_defines.svh"
module rcc_codec_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, valid = 0, slow = 0, tx_ready, err, txv, last, rdy;
  logic [6:0] cause = 7'h00;
  logic [3:0] dlen = 4'h0;
  logic [8*`RCC_DIAG_MAX_OCTETS-1:0] diag = '0;
  logic [7:0] data;
  logic [3:0] dl [5] = '{4'h0, 4'h3, 4'h4, 4'hb, 4'h6};
  integer seed = 61650;
  int fail_count = 0, num_checks = 0, cycles = 0;
  rcc_codec uut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(valid), .REQ_READY_OUT(rdy),
    .REQ_CAUSE_IN(cause), .REQ_DIAG_LEN_IN(dlen), .REQ_DIAG_IN(diag), .REQ_ERR_OUT(err),
    .TX_VALID_OUT(txv), .TX_READY_IN(tx_ready), .TX_DATA_OUT(data), .TX_LAST_OUT(last));
  rcc_exchange_model lex (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .valid_in(txv),
    .data_in(data), .last_in(last), .ready_out(tx_ready));
  initial forever #50 clk = ~clk;
  // diagnostic lengths each cause may carry; anything else must be refused
  function automatic bit legal(input logic [6:0] c, input logic [3:0] d);
    case (c)
      7'h00, 7'h01, 7'h02, 7'h07: return d == 4'h0;
      7'h03, 7'h06, 7'h09, 7'h0b: return d == 4'h4;
      7'h04, 7'h08, 7'h0c, 7'h0d, 7'h0f, 7'h10: return d == 4'h4 || d == 4'hb;
      7'h05, 7'h0a, 7'h0e: return d == 4'h3 || d == 4'hb;
      default: return 1'b0;
    endcase
  endfunction : legal
  task automatic check(input bit ok);
    num_checks++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED at %0t: cause %h diag length %0d", $time, cause, dlen);
    end
  endtask : check
  // one request, held until taken, then the sink's copy is compared octet by octet
  task automatic send(input logic [6:0] c, input logic [3:0] d);
    int base;
    int k;
    @(negedge clk);
    base = lex.elems;
    cause = c;
    dlen = d;
    diag = 88'({$random(seed), $random(seed), $random(seed)});
    valid = 1'b1;
    for (k = 0; rdy !== 1'b1 && k < 40; k++) @(negedge clk);
    @(negedge clk);
    valid = 1'b0;
    if (!legal(c, d)) begin
      check(err === 1'b1 && txv === 1'b0 && rdy === 1'b1);
      return;
    end
    check(err === 1'b0 && txv === 1'b1);
    for (k = 0; lex.elems == base && k < 200; k++) @(negedge clk);
    check(lex.elems == base + 1);
    check(lex.oct[0] === `RCC_IE_ID && lex.oct[1] === {4'h0, d} + 8'h01);
    check(lex.oct[2] === {1'b1, c});
    for (k = 0; k < d; k++) check(lex.oct[3 + k] === diag[8 * k +: 8]);
  endtask : send
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  // every defined code plus two reserved ones against diagnostic lengths 0, 3, 4, 11 and 6, then corners
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int c = 0; c < 19; c++) foreach (dl[i]) send(7'(c), dl[i]);
    send(7'h7f, 4'h0);
    send(7'h10, 4'hf);
    $display("code table test done");
    slow = 1'b1;
    repeat (80) send(7'($random(seed) & 15), dl[$random(seed) & 3]);
    $display("random stall test done");
    check(lex.len_errs == 0 && lex.elems > 0);
    results();
  end
  // the whole run needs under two thousand cycles; a hang stops here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
endmodule : rcc_codec_test
